// ==== core/amfm_defines.vh ====
// Constants for the AM/FM modulation control block
// Overview of operation
// - Only one modulation mode active; enabling AM or FM turns the other off.
// - Enabling AM or FM turns sweep and burst off.
// - AM output starts at once from the already stored settings.
// - Carrier is sine, square, ramp or arb; pulse, noise and dc refused.
// - Carrier frequency from 1 uHz to 80/80/1/25 MHz by shape, default 1 kHz.
// - Modulating shape: sine, square, ramp, triangle, falling ramp, noise, arb.
// - Arbitrary modulating waveform decimated down to at most 8K points.
// - AM modulating rate 2 mHz to 20 kHz, default 100 Hz.
// - FM modulating rate 2 mHz to 20 kHz, default 10 Hz.
// - Depth 0..120 %, default 100; 0 % gives half amplitude, 100 % full.
// - External AM input of +-5 V scales depth: +5 V max, -5 V min amplitude.
// - AM and FM source internal or external, default internal.
// - Deviation 5 Hz to 40.05 MHz, 550 kHz ramp, 12.55 MHz arb, default 100 Hz.
// - With FM enabled, deviation is clamped to the carrier frequency.
// - Carrier plus deviation at most shape maximum plus 100 kHz, else clamped.
// - Internal AM/FM sync is 50 % square, high in modulating first half.
// - External FM input of +-5 V scales deviation linearly, both signs.
`ifndef AFM_DEFINES_VH
`define AFM_DEFINES_VH

// Configuration field selectors
`define AFM_A_AM_EN 4'h0
`define AFM_A_FM_EN 4'h1
`define AFM_A_SWEEP_EN 4'h2
`define AFM_A_BURST_EN 4'h3
`define AFM_A_CAR_SHAPE 4'h4
`define AFM_A_CAR_FREQ 4'h5
`define AFM_A_AM_SHAPE 4'h6
`define AFM_A_FM_SHAPE 4'h7
`define AFM_A_AM_RATE 4'h8
`define AFM_A_FM_RATE 4'h9
`define AFM_A_DEPTH 4'hA
`define AFM_A_DEV 4'hB
`define AFM_A_AM_SRC 4'hC
`define AFM_A_FM_SRC 4'hD

// Carrier shape codes
`define AFM_CAR_SINE 3'h0
`define AFM_CAR_SQUARE 3'h1
`define AFM_CAR_RAMP 3'h2
`define AFM_CAR_ARB 3'h3

// Modulating shape codes
`define AFM_MOD_SINE 3'h0
`define AFM_MOD_SQUARE 3'h1
`define AFM_MOD_RAMP 3'h2
`define AFM_MOD_TRI 3'h3
`define AFM_MOD_FALL 3'h4
`define AFM_MOD_NOISE 3'h5
`define AFM_MOD_ARB 3'h6

// Source select
`define AFM_SRC_INT 1'b0
`define AFM_SRC_EXT 1'b1

// Frequency units, all frequencies held in micro-hertz
`define AFM_UHZ_1E3 48'h3E8
`define AFM_UHZ_1E10 48'h2540BE400
`define AFM_UHZ_MHZ 48'hE8D4A51000

// Carrier limits and default
`define AFM_CAR_MIN 48'h1
`define AFM_CAR_MAX_SQ (48'h50 * `AFM_UHZ_MHZ)
`define AFM_CAR_MAX_RAMP `AFM_UHZ_MHZ
`define AFM_CAR_MAX_ARB (48'h19 * `AFM_UHZ_MHZ)
`define AFM_CAR_RST 48'h3B9ACA00
`define AFM_DEV_MARGIN 48'h174876E800

// Modulating rate limits and defaults
`define AFM_RATE_MIN 48'h7D0
`define AFM_RATE_MAX 48'h4A817C800
`define AFM_AM_RATE_RST 36'h5F5E100
`define AFM_FM_RATE_RST 36'h989680

// Deviation limits and default
`define AFM_DEV_MIN 48'h4C4B40
`define AFM_DEV_MAX (48'hFA5 * `AFM_UHZ_1E10)
`define AFM_DEV_MAX_RAMP (48'h37 * `AFM_UHZ_1E10)
`define AFM_DEV_MAX_ARB (48'h4E7 * `AFM_UHZ_1E10)
`define AFM_DEV_RST 48'h5F5E100

// Depth limits, default and percent-to-Q15 scale (x/64)
`define AFM_DEPTH_MAX 7'h78
`define AFM_DEPTH_RST 7'h64
`define AFM_DEPTH_SCALE 16'h28F6
`define AFM_GAIN_HALF 19'h04000
`define AFM_GAIN_FULL 16'h8000

// Phase increment: rate_uHz * 2^48 / 100 MHz = rate * MULT >> 14
`define AFM_INC_MULT 16'hB425

// Arbitrary modulating memory
`define AFM_ARB_POINTS 14'h2000
`define AFM_LFSR_SEED 16'hACE1

`endif

// ==== core/amfm_mod_source.v ====
// Internal modulating waveform generator with decimated arbitrary memory
`default_nettype none
`include "amfm_defines.vh"
module amfm_mod_source (
    input wire clock,
    input wire sys_rst,
    input wire clockEnable,
    input wire run,
    input wire [35:0] rate,
    input wire [2:0] shape,
    input wire arbLoadStart,
    input wire [16:0] arbLength,
    input wire arbSampleValid,
    input wire [15:0] arbSample,
    output reg [15:0] sample_r,
    output reg syncHigh_r
);
    reg [47:0] phase_r;
    reg [15:0] lfsr_r;
    reg [3:0] stride_r;
    reg [3:0] skip_r;
    reg [13:0] wrIdx_r;
    reg [15:0] arbRd_r;
    reg [15:0] arbMem [0:8191];
    reg [15:0] sampleNxt;
    wire [51:0] incProd = {16'h0000, rate} * `AFM_INC_MULT;
    wire [15:0] p = phase_r[47:32];
    wire [29:0] parab = {15'h0000, p[14:0]} * (15'h7FFF - p[14:0]);
    wire [15:0] sineMag = parab[29:28] != 2'b00 ? 16'h7FFF : {1'b0, parab[27:13]};
    wire [15:0] rampUp = {~p[15], p[14:0]};
    wire [15:0] triUp = {~p[14], p[13:0], 1'b0};
    wire [29:0] arbIdxProd = {14'h0000, p} * wrIdx_r;
    wire [16:0] strideSum = arbLength + 17'h01FFF;

    // Phase accumulator, restarts at zero whenever the mode is idle
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= 48'h0;
            lfsr_r <= `AFM_LFSR_SEED;
        end else if (clockEnable) begin
            phase_r <= run ? phase_r + {10'h000, incProd[51:14]} : 48'h0;
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stride_r <= 4'h1;
            skip_r <= 4'h0;
            wrIdx_r <= 14'h0;
        end else if (clockEnable) begin
            if (arbLoadStart) begin
                stride_r <= strideSum[16:13] == 4'h0 ? 4'h1 : strideSum[16:13];
                skip_r <= 4'h0;
                wrIdx_r <= 14'h0;
            end else if (arbSampleValid) begin
                skip_r <= (skip_r == stride_r - 4'h1) ? 4'h0 : skip_r + 4'h1;
                if (skip_r == 4'h0 && wrIdx_r != `AFM_ARB_POINTS) begin
                    wrIdx_r <= wrIdx_r + 14'h1;
                end
            end
        end
    end

    // Memory write of kept samples and registered playback read
    always @(posedge clock) begin
        if (clockEnable) begin
            if (!arbLoadStart && arbSampleValid && skip_r == 4'h0 &&
                wrIdx_r != `AFM_ARB_POINTS) begin
                arbMem[wrIdx_r[12:0]] <= arbSample;
            end
            arbRd_r <= arbMem[arbIdxProd[28:16]];
        end
    end

    always @* begin
        case (shape)
            `AFM_MOD_SINE: sampleNxt = p[15] ? (~sineMag + 16'h1) : sineMag;
            `AFM_MOD_SQUARE: sampleNxt = p[15] ? 16'h8001 : 16'h7FFF;
            `AFM_MOD_RAMP: sampleNxt = rampUp;
            `AFM_MOD_TRI: sampleNxt = p[15] ? ~triUp : triUp;
            `AFM_MOD_FALL: sampleNxt = ~rampUp;
            `AFM_MOD_NOISE: sampleNxt = lfsr_r;
            `AFM_MOD_ARB: sampleNxt = wrIdx_r == 14'h0 ? 16'h0000 : arbRd_r;
            default: sampleNxt = 16'h0000;
        endcase
    end

    // Registered sample and sync
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sample_r <= 16'h0000;
            syncHigh_r <= 1'b0;
        end else if (clockEnable) begin
            sample_r <= sampleNxt;
            syncHigh_r <= run & ~p[15];
        end
    end
endmodule
`default_nettype wire

// ==== core/amfm_mod_ctrl.v ====
// AM/FM modulation mode control, parameter limiting and modulation math
`default_nettype none
`include "amfm_defines.vh"
module amfm_mod_ctrl (
    input wire clock,
    input wire sys_rst,
    input wire clockEnable,
    input wire cfgWrite,
    input wire [3:0] cfgAddr,
    input wire [47:0] cfgData,
    input wire arbLoadStart,
    input wire [16:0] arbLength,
    input wire arbSampleValid,
    input wire [15:0] arbSample,
    input wire [15:0] extModIn,
    input wire carrierSyncIn,
    output reg amplitudeModEnable_r,
    output reg frequencyModEnable_r,
    output reg sweepEnable_r,
    output reg burstEnable_r,
    output reg [2:0] carrierShape_r,
    output reg [47:0] carrierFreq_r,
    output reg [2:0] ampModInternalShape_r,
    output reg [2:0] freqModInternalShape_r,
    output reg [35:0] ampModInternalRate_r,
    output reg [35:0] freqModInternalRate_r,
    output reg [6:0] modDepthPercent_r,
    output reg [47:0] peakFreqDeviation_r,
    output reg ampModSourceSelect_r,
    output reg freqModSourceSelect_r,
    output reg [15:0] ampGain_r,
    output reg [47:0] instFreq_r,
    output reg modSyncOut_r,
    output reg cfgRefused_r
);
    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function [47:0] carMax;
        input [2:0] s;
        begin
            case (s)
                `AFM_CAR_RAMP: carMax = `AFM_CAR_MAX_RAMP;
                `AFM_CAR_ARB: carMax = `AFM_CAR_MAX_ARB;
                default: carMax = `AFM_CAR_MAX_SQ;
            endcase
        end
    endfunction

    function [47:0] devCap;
        input [2:0] s;
        begin
            case (s)
                `AFM_CAR_RAMP: devCap = `AFM_DEV_MAX_RAMP;
                `AFM_CAR_ARB: devCap = `AFM_DEV_MAX_ARB;
                default: devCap = `AFM_DEV_MAX;
            endcase
        end
    endfunction

    function [47:0] clampU;
        input [47:0] v;
        input [47:0] lo;
        input [47:0] hi;
        begin
            if (v < lo) begin
                clampU = lo;
            end else if (v > hi) begin
                clampU = hi;
            end else begin
                clampU = v;
            end
        end
    endfunction

    function [47:0] minU;
        input [47:0] a;
        input [47:0] b;
        begin
            minU = a < b ? a : b;
        end
    endfunction

    // ------------------------------------------------------------
    // Internal state and shared signals
    // ------------------------------------------------------------
    reg [47:0] devRequest_r;
    reg [47:0] devLimit;
    reg [47:0] rateClamp;
    wire [15:0] srcSample;
    wire srcSync;
    wire modActive = amplitudeModEnable_r | frequencyModEnable_r;
    wire activeExt = amplitudeModEnable_r ? ampModSourceSelect_r : freqModSourceSelect_r;
    wire [35:0] activeRate = amplitudeModEnable_r ? ampModInternalRate_r
                                                  : freqModInternalRate_r;
    wire [2:0] activeShape = amplitudeModEnable_r ? ampModInternalShape_r
                                                  : freqModInternalShape_r;
    wire [15:0] modValue = activeExt ? extModIn : srcSample;
    wire [47:0] shapeMax = carMax(carrierShape_r);

    // Internal modulating source shared by AM and FM, only one runs at a time
    amfm_mod_source modSource (
        .clock(clock),
        .sys_rst(sys_rst),
        .clockEnable(clockEnable),
        .run(modActive & ~activeExt),
        .rate(activeRate),
        .shape(activeShape),
        .arbLoadStart(arbLoadStart),
        .arbLength(arbLength),
        .arbSampleValid(arbSampleValid),
        .arbSample(arbSample),
        .sample_r(srcSample),
        .syncHigh_r(srcSync)
    );

    // Saturated modulating rate of the write data
    always @* begin
        rateClamp = clampU(cfgData, `AFM_RATE_MIN, `AFM_RATE_MAX);
    end

    // ------------------------------------------------------------
    // Configuration writes and mode exclusion
    // ------------------------------------------------------------
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            amplitudeModEnable_r <= 1'b0;
            frequencyModEnable_r <= 1'b0;
            sweepEnable_r <= 1'b0;
            burstEnable_r <= 1'b0;
            carrierShape_r <= `AFM_CAR_SINE;
            carrierFreq_r <= `AFM_CAR_RST;
            ampModInternalShape_r <= `AFM_MOD_SINE;
            freqModInternalShape_r <= `AFM_MOD_SINE;
            ampModInternalRate_r <= `AFM_AM_RATE_RST;
            freqModInternalRate_r <= `AFM_FM_RATE_RST;
            modDepthPercent_r <= `AFM_DEPTH_RST;
            devRequest_r <= `AFM_DEV_RST;
            ampModSourceSelect_r <= `AFM_SRC_INT;
            freqModSourceSelect_r <= `AFM_SRC_INT;
            cfgRefused_r <= 1'b0;
        end else if (clockEnable) begin
            cfgRefused_r <= 1'b0;
            if (cfgWrite) begin
                case (cfgAddr)
                    `AFM_A_AM_EN: begin
                        amplitudeModEnable_r <= cfgData[0];
                        if (cfgData[0]) begin
                            frequencyModEnable_r <= 1'b0;
                            sweepEnable_r <= 1'b0;
                            burstEnable_r <= 1'b0;
                        end
                    end
                    `AFM_A_FM_EN: begin
                        frequencyModEnable_r <= cfgData[0];
                        if (cfgData[0]) begin
                            amplitudeModEnable_r <= 1'b0;
                            sweepEnable_r <= 1'b0;
                            burstEnable_r <= 1'b0;
                        end
                    end
                    `AFM_A_SWEEP_EN: begin
                        sweepEnable_r <= cfgData[0];
                        if (cfgData[0]) begin
                            amplitudeModEnable_r <= 1'b0;
                            frequencyModEnable_r <= 1'b0;
                            burstEnable_r <= 1'b0;
                        end
                    end
                    `AFM_A_BURST_EN: begin
                        burstEnable_r <= cfgData[0];
                        if (cfgData[0]) begin
                            amplitudeModEnable_r <= 1'b0;
                            frequencyModEnable_r <= 1'b0;
                            sweepEnable_r <= 1'b0;
                        end
                    end
                    `AFM_A_CAR_SHAPE: begin
                        if (cfgData[47:2] == 46'h0) begin
                            carrierShape_r <= cfgData[2:0];
                            carrierFreq_r <= minU(carrierFreq_r, carMax(cfgData[2:0]));
                        end else begin
                            cfgRefused_r <= 1'b1;
                        end
                    end
                    `AFM_A_CAR_FREQ: carrierFreq_r <= clampU(cfgData, `AFM_CAR_MIN, shapeMax);
                    `AFM_A_AM_SHAPE: begin
                        if (cfgData <= {45'h0, `AFM_MOD_ARB}) begin
                            ampModInternalShape_r <= cfgData[2:0];
                        end else begin
                            cfgRefused_r <= 1'b1;
                        end
                    end
                    `AFM_A_FM_SHAPE: begin
                        if (cfgData <= {45'h0, `AFM_MOD_ARB}) begin
                            freqModInternalShape_r <= cfgData[2:0];
                        end else begin
                            cfgRefused_r <= 1'b1;
                        end
                    end
                    `AFM_A_AM_RATE: ampModInternalRate_r <= rateClamp[35:0];
                    `AFM_A_FM_RATE: freqModInternalRate_r <= rateClamp[35:0];
                    `AFM_A_DEPTH: begin
                        if (cfgData > {41'h0, `AFM_DEPTH_MAX}) begin
                            modDepthPercent_r <= `AFM_DEPTH_MAX;
                        end else begin
                            modDepthPercent_r <= cfgData[6:0];
                        end
                    end
                    `AFM_A_DEV: devRequest_r <= clampU(cfgData, `AFM_DEV_MIN, `AFM_DEV_MAX);
                    `AFM_A_AM_SRC: ampModSourceSelect_r <= cfgData[0];
                    `AFM_A_FM_SRC: freqModSourceSelect_r <= cfgData[0];
                    default: cfgRefused_r <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Deviation limiting against shape and carrier
    // ------------------------------------------------------------
    always @* begin
        devLimit = minU(devRequest_r, devCap(carrierShape_r));
        // sum within shape max plus margin
        devLimit = minU(devLimit, shapeMax + `AFM_DEV_MARGIN - carrierFreq_r);
        // not above carrier while FM on
        if (frequencyModEnable_r) begin
            devLimit = minU(devLimit, carrierFreq_r);
        end
    end

    // ------------------------------------------------------------
    // Modulation arithmetic
    // ------------------------------------------------------------
    wire [22:0] depthProd = {16'h0000, modDepthPercent_r} * `AFM_DEPTH_SCALE;
    wire signed [33:0] amProd = $signed({17'h00000, depthProd[22:6]}) * $signed(modValue);
    wire signed [18:0] gainSum = $signed(`AFM_GAIN_HALF) + $signed(amProd[33:15]);
    wire signed [64:0] fmProd = $signed({17'h00000, peakFreqDeviation_r}) * $signed(modValue);
    wire signed [49:0] freqSum = $signed({2'b00, carrierFreq_r}) + $signed(fmProd[64:15]);

    // Registered outputs of the modulation path
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            peakFreqDeviation_r <= `AFM_DEV_RST;
            ampGain_r <= `AFM_GAIN_FULL;
            instFreq_r <= `AFM_CAR_RST;
            modSyncOut_r <= 1'b0;
        end else if (clockEnable) begin
            peakFreqDeviation_r <= devLimit;
            if (!amplitudeModEnable_r) begin
                ampGain_r <= `AFM_GAIN_FULL;
            end else if (gainSum[18]) begin
                ampGain_r <= 16'h0000;
            end else if (gainSum[17:16] != 2'b00) begin
                ampGain_r <= 16'hFFFF;
            end else begin
                ampGain_r <= gainSum[15:0];
            end
            if (!frequencyModEnable_r) begin
                instFreq_r <= carrierFreq_r;
            end else if (freqSum[49]) begin
                instFreq_r <= 48'h0;
            end else begin
                instFreq_r <= freqSum[47:0];
            end
            modSyncOut_r <= (modActive & ~activeExt) ? srcSync : carrierSyncIn;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/amfm_monitor.sv ====
// Assertion checker bound to the modulation control block
`default_nettype none
`include "amfm_defines.vh"
module amfm_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clockEnable,
    input wire logic cfgWrite,
    input wire logic [3:0] cfgAddr,
    input wire logic [47:0] cfgData,
    input wire logic amplitudeModEnable_r,
    input wire logic frequencyModEnable_r,
    input wire logic sweepEnable_r,
    input wire logic burstEnable_r,
    input wire logic [2:0] carrierShape_r,
    input wire logic [47:0] carrierFreq_r,
    input wire logic [35:0] ampModInternalRate_r,
    input wire logic [6:0] modDepthPercent_r,
    input wire logic [47:0] peakFreqDeviation_r,
    input wire logic [15:0] ampGain_r,
    input wire logic [47:0] instFreq_r,
    input wire logic cfgRefused_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic wrT;
    // Write taken on this edge
    assign wrT = cfgWrite && clockEnable;
    a_single_mode: assert property (
        !(amplitudeModEnable_r && frequencyModEnable_r)) else $error("two mod modes on");
    a_am_clears_all: assert property (
        wrT && cfgAddr == 4'h0 && cfgData[0] |=> amplitudeModEnable_r
        && !frequencyModEnable_r && !sweepEnable_r && !burstEnable_r) else $error("am exclusion");
    a_fm_clears_all: assert property (
        wrT && cfgAddr == 4'h1 && cfgData[0] |=> frequencyModEnable_r
        && !amplitudeModEnable_r && !sweepEnable_r && !burstEnable_r) else $error("fm exclusion");
    a_shape_refused: assert property (
        wrT && cfgAddr == 4'h4 && cfgData > 48'h3 |=> cfgRefused_r && $stable(carrierShape_r))
        else $error("bad carrier taken");
    a_depth_limit: assert property (
        modDepthPercent_r <= `AFM_DEPTH_MAX) else $error("depth over limit");
    a_rate_limit: assert property (
        ampModInternalRate_r >= 36'h7D0 && ampModInternalRate_r <= 36'h4A817C800)
        else $error("am rate out of range");
    a_dev_carrier: assert property (
        (frequencyModEnable_r && $stable(carrierFreq_r))[*3] |->
        peakFreqDeviation_r <= carrierFreq_r) else $error("deviation above carrier");
    a_dev_ceiling: assert property (
        peakFreqDeviation_r <= `AFM_DEV_MAX) else $error("deviation over ceiling");
    a_gain_idle: assert property (
        !amplitudeModEnable_r [*2] |-> ampGain_r == `AFM_GAIN_FULL) else $error("gain moves");
    a_freq_idle: assert property (
        (!frequencyModEnable_r && $stable(carrierFreq_r))[*2] |-> instFreq_r == carrierFreq_r)
        else $error("freq moves");
    c_am_on: cover property (wrT && cfgAddr == 4'h0 && cfgData[0]);
    c_refused: cover property (cfgRefused_r);
    c_dev_clamp: cover property (frequencyModEnable_r && peakFreqDeviation_r == carrierFreq_r);
endmodule
bind amfm_mod_ctrl amfm_monitor i_amfm_monitor (.clock, .sys_rst, .clockEnable, .cfgWrite,
    .cfgAddr, .cfgData, .amplitudeModEnable_r, .frequencyModEnable_r, .sweepEnable_r,
    .burstEnable_r, .carrierShape_r, .carrierFreq_r, .ampModInternalRate_r,
    .modDepthPercent_r, .peakFreqDeviation_r, .ampGain_r, .instFreq_r, .cfgRefused_r);
`default_nettype wire

// ==== testbench/amfm_host_model.sv ====
// Host command model issuing single configuration writes
`default_nettype none
module amfm_host_model (
    input wire logic clock,
    output var logic cfgWrite,
    output var logic [3:0] cfgAddr,
    output var logic [47:0] cfgData
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cfgWrite = 1'b0;
        cfgAddr = 4'h0;
        cfgData = 48'h0;
    end
    // One strobe cycle; released fields show inverted junk
    task automatic put(input logic [3:0] a, input logic [47:0] d);
        @(negedge clock);
        cfgWrite = 1'b1;
        cfgAddr = a;
        cfgData = d;
        @(negedge clock);
        cfgWrite = 1'b0;
        cfgAddr = ~a;
        cfgData = ~d;
    endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking testbench for the modulation control block
`default_nettype none
`include "amfm_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, sysRst, clockEnable, carrierSyncIn, arbStart = 1'b0, arbValid = 1'b0;
    logic [15:0] extModIn, arbData = 16'h7FFF;
    wire logic cfgWrite, amOn, fmOn, swOn, buOn, amSrc, fmSrc, sync, refused;
    wire logic [3:0] cfgAddr;
    wire logic [47:0] cfgData, carFreq, dev, instF;
    wire logic [2:0] carShape, amShape, fmShape;
    wire logic [35:0] amRate, fmRate;
    wire logic [6:0] depth;
    wire logic [15:0] gain;
    int mismatches = 0;
    int samplesChecked = 0;
    amfm_host_model i_amfm_host_model (.clock(clock), .cfgWrite(cfgWrite),
        .cfgAddr(cfgAddr), .cfgData(cfgData));
    amfm_mod_ctrl i_amfm_mod_ctrl (.clock(clock), .sys_rst(sysRst), .clockEnable(clockEnable),
        .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgData(cfgData), .arbLoadStart(arbStart),
        .arbLength(17'h4000), .arbSampleValid(arbValid), .arbSample(arbData), .extModIn(extModIn),
        .carrierSyncIn(carrierSyncIn), .amplitudeModEnable_r(amOn), .frequencyModEnable_r(fmOn),
        .sweepEnable_r(swOn), .burstEnable_r(buOn), .carrierShape_r(carShape),
        .carrierFreq_r(carFreq), .ampModInternalShape_r(amShape),
        .freqModInternalShape_r(fmShape), .ampModInternalRate_r(amRate),
        .freqModInternalRate_r(fmRate), .modDepthPercent_r(depth), .peakFreqDeviation_r(dev),
        .ampModSourceSelect_r(amSrc), .freqModSourceSelect_r(fmSrc), .ampGain_r(gain),
        .instFreq_r(instF), .modSyncOut_r(sync), .cfgRefused_r(refused));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chkIn(input logic [47:0] got, input logic [47:0] lo, input logic [47:0] hi);
        samplesChecked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("BAD %0t got %0h outside %0h..%0h", $time, got, lo, hi);
        end
    endtask
    task automatic put(input logic [3:0] a, input logic [47:0] d);
        i_amfm_host_model.put(a, d);
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic endSim();
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Defaults after reset
    task automatic tReset();
        chk(carFreq, `AFM_CAR_RST);
        chk(amRate, `AFM_AM_RATE_RST);
        chk(fmRate, `AFM_FM_RATE_RST);
        chk(depth, 7'h64);
        chk(dev, `AFM_DEV_RST);
        chk({amSrc, fmSrc}, 2'b00);
        chk({carShape, amShape, fmShape}, 9'h000);
        chk({amOn, fmOn, swOn, buOn}, 4'h0);
    endtask
    // Mode exclusion, frozen writes, prompt start
    task automatic tMode();
        put(4'h2, 48'h1);
        put(4'h3, 48'h1);
        chk({swOn, buOn}, 2'b01);
        clockEnable = 1'b0;
        put(4'h0, 48'h1);
        clockEnable = 1'b1;
        chk(amOn, 1'b0);
        put(4'h0, 48'h1);
        chk({amOn, fmOn, swOn, buOn}, 4'h8);
        w(2);
        chk(sync, 1'b1);
        put(4'h1, 48'h1);
        chk({amOn, fmOn, swOn, buOn}, 4'h4);
        put(4'h1, 48'h0);
    endtask
    // Every shape code, refused codes and unmapped field
    task automatic tRefuse();
        for (int s = 0; s < 8; s++) begin
            put(4'h4, 48'(s));
            chk(refused, s > 3);
            chk(carShape, s > 3 ? 3'h3 : 3'(s));
            put(4'h6, 48'(s));
            chk(amShape, s > 6 ? 3'h6 : 3'(s));
            put(4'h7, 48'(s));
            chk(refused, s > 6);
            chk(fmShape, s > 6 ? 3'h6 : 3'(s));
        end
        put(4'hE, 48'h0);
        chk(refused, 1'b1);
    endtask
    // Saturation of frequencies, rates and depth
    task automatic tLimits();
        put(4'h4, 48'h2);
        put(4'h5, 48'hFFFFFFFFFFFF);
        chk(carFreq, `AFM_UHZ_MHZ);
        put(4'h5, 48'h0);
        chk(carFreq, 48'h1);
        put(4'h4, 48'h3);
        put(4'h5, 48'hFFFFFFFFFFFF);
        chk(carFreq, `AFM_CAR_MAX_ARB);
        put(4'h8, 48'h0);
        chk(amRate, 36'h7D0);
        put(4'h9, 48'hFFFFFFFFFFFF);
        chk(fmRate, 36'h4A817C800);
        put(4'hA, 48'h7F);
        chk(depth, 7'h78);
    endtask
    // Deviation clamping against carrier and shape
    task automatic tDev();
        put(4'h4, 48'h0);
        put(4'h5, `AFM_CAR_RST);
        put(4'hB, 48'h0);
        w(1);
        chk(dev, `AFM_DEV_MIN);
        put(4'hB, `AFM_UHZ_1E10);
        put(4'h1, 48'h1);
        w(1);
        chk(dev, `AFM_CAR_RST);
        put(4'h4, 48'h2);
        put(4'h5, `AFM_UHZ_MHZ);
        put(4'hB, 48'hFFFFFFFFFFFF);
        w(1);
        chk(dev, `AFM_DEV_MARGIN);
        put(4'h1, 48'h0);
        put(4'h5, 48'h1);
        w(1);
        chk(dev, `AFM_DEV_MAX_RAMP);
    endtask
    // External input scaling for FM then AM
    task automatic tExt();
        put(4'h4, 48'h0);
        put(4'h5, `AFM_CAR_RST);
        put(4'hB, `AFM_DEV_RST);
        put(4'hD, 48'h1);
        extModIn = 16'h7FFF;
        put(4'h1, 48'h1);
        w(3);
        chkIn(instF, `AFM_CAR_RST + `AFM_DEV_RST - 48'hF4240, `AFM_CAR_RST + `AFM_DEV_RST);
        extModIn = 16'h8000;
        w(2);
        chkIn(instF, `AFM_CAR_RST - `AFM_DEV_RST - 48'hF4240, `AFM_CAR_RST - 48'h5F3DA00);
        put(4'hC, 48'h1);
        put(4'hA, 48'h0);
        extModIn = 16'h7FFF;
        put(4'h0, 48'h1);
        w(2);
        chk(gain, 16'h4000);
        put(4'hA, 48'h64);
        w(2);
        chkIn(gain, 16'h7F00, 16'h8100);
        extModIn = 16'h8000;
        carrierSyncIn = 1'b1;
        w(2);
        chkIn(gain, 16'h0000, 16'h0100);
        chk(sync, 1'b1);
    endtask
    // Decimated arbitrary wave
    task automatic tArb();
        arbStart = 1'b1;
        w(1);
        arbStart = 1'b0;
        arbValid = 1'b1;
        w(1);
        arbData = 16'h8000;
        w(1);
        arbValid = 1'b0;
        put(4'hC, 48'h0);
        w(2);
        chkIn(gain, 16'h7F00, 16'h8100);
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        sysRst = 1'b1;
        clockEnable = 1'b1;
        carrierSyncIn = 1'b0;
        extModIn = 16'h0000;
        repeat (8) @(posedge clock);
        @(negedge clock);
        sysRst = 1'b0;
        tReset();
        tMode();
        tRefuse();
        tLimits();
        tDev();
        tExt();
        tArb();
        endSim();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        mismatches++;
        endSim();
    end
endmodule
`default_nettype wire
